// File: pkg/smh_regs.svh
// Constants for the health command handler and its controller.
`ifndef SMH_REGS_SVH
`define SMH_REGS_SVH

// Command and sub-command codes
`define SMH_CMD_HEALTH   8'hb0
`define SMH_FEAT_READ    8'hd0
`define SMH_FEAT_EN      8'hd8
`define SMH_FEAT_DIS     8'hd9
`define SMH_SIG_MID      8'h4f
`define SMH_SIG_HIGH     8'hc2

// Status and error bit positions
`define SMH_ST_BSY       7
`define SMH_ST_DRDY      6
`define SMH_ST_DF        5
`define SMH_ST_DRQ       3
`define SMH_ST_ERR       0
`define SMH_ER_ABRT      2
`define SMH_ST_RESET     8'h40

// Health structure byte offsets
`define SMH_B_REV        9'd0
`define SMH_B_OFFLINE    9'd362
`define SMH_B_SELFTEST   9'd364
`define SMH_B_CAP        9'd368
`define SMH_B_POLL_SHORT 9'd372
`define SMH_B_POLL_EXT   9'd373
`define SMH_B_POLL_CONV  9'd374
`define SMH_B_INIT_BAD   9'd396
`define SMH_B_RT_BAD     9'd398
`define SMH_B_SPARE      9'd400
`define SMH_B_ERASE      9'd401
`define SMH_LAST_WORD    8'hff

// Controller register byte addresses
`define SMH_A_CTRL       8'h00
`define SMH_A_STAT       8'h04
`define SMH_A_DATA       8'h08
`define SMH_A_IRQ        8'h0c
`define SMH_A_MASK       8'h10

// Controller field positions
`define SMH_C_GO         0
`define SMH_C_OP_LSB     1
`define SMH_C_DEV        4
`define SMH_I_DONE       0
`define SMH_I_ERR        1
`define SMH_I_DRQ        2
`define SMH_S_BUSY       16
`define SMH_S_EN         17
`define SMH_S_DEV        18

`endif

// File: pkg/smh_pkg.sv
// Types shared by the health command handler and its controller.
package smh_pkg;
   typedef enum logic [1:0] {SMH_D_IDLE, SMH_D_EXEC, SMH_D_XFER} smh_dst_t;
   typedef enum logic [2:0] {SMH_H_IDLE, SMH_H_CMD, SMH_H_WAIT,
                             SMH_H_XFER} smh_hst_t;
   typedef enum logic [1:0] {SMH_OP_READ, SMH_OP_EN, SMH_OP_DIS,
                             SMH_OP_BAD} smh_op_t;
endpackage : smh_pkg

// File: pkg/smh_if.sv
// Taskfile link between the health controller and the storage device.
`timescale 1ns/100ps
`default_nettype none
interface smh_if;
   logic [7:0]  tf_feat;
   logic [7:0]  tf_lba_mid;
   logic [7:0]  tf_lba_high;
   logic        tf_dev;
   logic [7:0]  tf_cmd;
   logic        cmd_wr;
   logic        data_rd;
   logic [7:0]  st_flags;
   logic [7:0]  err_flags;
   logic        dev_echo;
   logic [15:0] rd_word;

   modport dev  (input  tf_feat, tf_lba_mid, tf_lba_high, tf_dev, tf_cmd,
                        cmd_wr, data_rd,
                 output st_flags, err_flags, dev_echo, rd_word);
   modport host (output tf_feat, tf_lba_mid, tf_lba_high, tf_dev, tf_cmd,
                        cmd_wr, data_rd,
                 input  st_flags, err_flags, dev_echo, rd_word);
endinterface : smh_if
`default_nettype wire

// File: hw/smh_dev.sv
// Device end: decodes health sub-commands and streams the health block.
// Operation
// R01: Read command returns whole health block
// R02: Revision, offline, self-test, capability byte places
// R03: Poll times at bytes 372, 373, 374
// R04: Bad block counts, MSB at lower byte
// R05: Spare, erase count, checksum in byte 511
// R06: Enable is B0h with D8h, non-data
// R07: Enable turns health monitoring on
// R08: Disable is B0h with D9h, non-data
// R09: Host reads only when ready and enabled
// R10: Success clears BSY, DF, DRQ, ERR; sets DRDY
// R11: Device-select bit reported back unchanged
// R12: Read is B0h with D0h, PIO data-in
// R13: Disable turns monitoring off, needs enabled
// R14: Signature 4Fh/C2h required, else abort
// R15: Read/disable while disabled aborts with error
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "smh_regs.svh"
module smh_dev #(
   parameter logic [15:0] REV_CODE   = 16'h0001,
   parameter logic [7:0]  OFFLINE_ST = 8'h00,
   parameter logic [15:0] SELFTEST   = 16'h0000,
   parameter logic [15:0] CAPABILITY = 16'h0003,
   parameter logic [7:0]  POLL_SHORT = 8'h01,
   parameter logic [7:0]  POLL_EXT   = 8'h0a,
   parameter logic [7:0]  POLL_CONV  = 8'h02
) (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   smh_if.dev               link,
   input  wire logic [15:0] init_bad_i,
   input  wire logic [15:0] rt_bad_i,
   input  wire logic [7:0]  spare_i,
   input  wire logic [15:0] erase_i,
   output logic             enabled_o,
   output logic             busy_o
);

   typedef struct packed {
      smh_pkg::smh_dst_t st;
      logic              en;
      logic [7:0]        stat;
      logic [7:0]        err;
      logic              dev;
      logic [7:0]        feat;
      logic              sig_ok;
      logic              is_health;
      logic [7:0]        idx;
      logic [7:0]        sum;
      logic [15:0]       word;
      logic [15:0]       ib;
      logic [15:0]       rb;
      logic [7:0]        sp;
      logic [15:0]       er;
   } smh_dev_state_t;

   smh_dev_state_t s_q;
   smh_dev_state_t s_d;

   // One byte of the health block, from the snapshot taken at command start
   function automatic logic [7:0] byte_at(input logic [8:0]   a,
                                          input smh_dev_state_t s);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         `SMH_B_REV:             b = REV_CODE[7:0];        // R02
         `SMH_B_REV+9'd1:        b = REV_CODE[15:8];       // R02
         `SMH_B_OFFLINE:         b = OFFLINE_ST;           // R02
         `SMH_B_SELFTEST:        b = SELFTEST[7:0];        // R02
         `SMH_B_SELFTEST+9'd1:   b = SELFTEST[15:8];       // R02
         `SMH_B_CAP:             b = CAPABILITY[7:0];      // R02
         `SMH_B_CAP+9'd1:        b = CAPABILITY[15:8];     // R02
         `SMH_B_POLL_SHORT:      b = POLL_SHORT;           // R03
         `SMH_B_POLL_EXT:        b = POLL_EXT;             // R03
         `SMH_B_POLL_CONV:       b = POLL_CONV;            // R03
         `SMH_B_INIT_BAD:        b = s.ib[15:8];           // R04
         `SMH_B_INIT_BAD+9'd1:   b = s.ib[7:0];            // R04
         `SMH_B_RT_BAD:          b = s.rb[15:8];           // R04
         `SMH_B_RT_BAD+9'd1:     b = s.rb[7:0];            // R04
         `SMH_B_SPARE:           b = s.sp;                 // R05
         `SMH_B_ERASE:           b = s.er[15:8];           // R05
         `SMH_B_ERASE+9'd1:      b = s.er[7:0];            // R05
         default:                b = 8'h00;
      endcase
      return b;
   endfunction : byte_at

   // Loads word k into the output and accumulates the checksum
   function automatic smh_dev_state_t load_word(input logic [7:0] k,
                                                input smh_dev_state_t s);
      smh_dev_state_t r;
      logic [7:0]     lo;
      logic [7:0]     hi;
      r  = s;
      lo = byte_at({k, 1'b0}, s);
      if (k == `SMH_LAST_WORD) begin
         hi = 8'(8'h00 - s.sum - lo);                      // R05
      end else begin
         hi = byte_at({k, 1'b1}, s);
      end
      r.idx  = k;
      r.word = {hi, lo};
      r.sum  = 8'(s.sum + lo + hi);
      return r;
   endfunction : load_word

   // Status after a command that failed its checks
   function automatic smh_dev_state_t abort_cmd(input smh_dev_state_t s);
      smh_dev_state_t r;
      r      = s;
      r.stat = 8'h00;
      r.stat[`SMH_ST_DRDY] = 1'b1;
      r.stat[`SMH_ST_ERR]  = 1'b1;                         // R15
      r.err  = 8'h00;
      r.err[`SMH_ER_ABRT]  = 1'b1;                         // R14
      r.st   = smh_pkg::SMH_D_IDLE;
      return r;
   endfunction : abort_cmd

   // Clean completion status
   function automatic smh_dev_state_t finish_ok(input smh_dev_state_t s);
      smh_dev_state_t r;
      r      = s;
      r.stat = 8'h00;
      r.stat[`SMH_ST_DRDY] = 1'b1;                         // R10
      r.err  = 8'h00;
      r.st   = smh_pkg::SMH_D_IDLE;
      return r;
   endfunction : finish_ok

   // Command decode and transfer sequencing
   always_comb begin
      s_d = s_q;
      case (s_q.st)
         smh_pkg::SMH_D_IDLE: begin
            if (link.cmd_wr) begin
               s_d.dev       = link.tf_dev;                // R11
               s_d.feat      = link.tf_feat;
               s_d.is_health = (link.tf_cmd == `SMH_CMD_HEALTH);
               s_d.sig_ok    = (link.tf_lba_mid == `SMH_SIG_MID) &&
                               (link.tf_lba_high == `SMH_SIG_HIGH); // R14
               s_d.ib        = init_bad_i;
               s_d.rb        = rt_bad_i;
               s_d.sp        = spare_i;
               s_d.er        = erase_i;
               s_d.stat      = 8'h00;
               s_d.stat[`SMH_ST_BSY] = 1'b1;
               s_d.st        = smh_pkg::SMH_D_EXEC;
            end
         end
         smh_pkg::SMH_D_EXEC: begin
            if (!s_q.is_health || !s_q.sig_ok) begin
               s_d = abort_cmd(s_q);                       // R14
            end else begin
               case (s_q.feat)
                  `SMH_FEAT_EN: begin
                     s_d    = finish_ok(s_q);              // R06
                     s_d.en = 1'b1;                        // R07
                  end
                  `SMH_FEAT_DIS: begin
                     if (!s_q.en) begin
                        s_d = abort_cmd(s_q);              // R15
                     end else begin
                        s_d    = finish_ok(s_q);           // R08
                        s_d.en = 1'b0;                     // R13
                     end
                  end
                  `SMH_FEAT_READ: begin
                     if (!s_q.en) begin
                        s_d = abort_cmd(s_q);              // R15
                     end else begin
                        s_d.sum  = 8'h00;
                        s_d      = load_word(8'h00, s_d);  // R12
                        s_d.stat = 8'h00;
                        s_d.stat[`SMH_ST_DRDY] = 1'b1;
                        s_d.stat[`SMH_ST_DRQ]  = 1'b1;     // R12
                        s_d.err  = 8'h00;
                        s_d.st   = smh_pkg::SMH_D_XFER;
                     end
                  end
                  default: s_d = abort_cmd(s_q);
               endcase
            end
         end
         smh_pkg::SMH_D_XFER: begin
            if (link.data_rd) begin
               if (s_q.idx == `SMH_LAST_WORD) begin
                  s_d = finish_ok(s_q);                    // R01
               end else begin
                  s_d = load_word(8'(s_q.idx + 8'h01), s_q); // R01
               end
            end
         end
         default: s_d.st = smh_pkg::SMH_D_IDLE;
      endcase
   end

   // State register, reset to ready and disabled
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_q      <= '0;
         s_q.stat <= `SMH_ST_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Link and user outputs straight from the state register
   assign link.st_flags  = s_q.stat;                       // R10
   assign link.err_flags = s_q.err;
   assign link.dev_echo  = s_q.dev;                        // R11
   assign link.rd_word   = s_q.word;
   assign enabled_o      = s_q.en;
   assign busy_o         = (s_q.st != smh_pkg::SMH_D_IDLE);

endmodule : smh_dev
`default_nettype wire

// File: hw/smh_host.sv
// Host end: AHB-Lite controlled issuer of health sub-commands.
`timescale 1ns/100ps
`default_nettype none
`include "smh_regs.svh"
module smh_host (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   smh_if.host              link,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hwdata_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic             irq_o
);

   typedef struct packed {
      smh_pkg::smh_hst_t st;
      smh_pkg::smh_op_t  op;
      logic              en;
      logic              dev;
      logic [7:0]        feat;
      logic              cmd_wr;
      logic              wr_pend;
      logic [7:0]        waddr;
      logic [31:0]       rdata;
      logic [2:0]        irq;
      logic [2:0]        mask;
   } smh_host_state_t;

   smh_host_state_t s_q;
   smh_host_state_t s_d;
   logic            acc;
   logic            go;
   logic [2:0]      ev;
   logic [7:0]      aoff;

   // Address phase accept; a read of the data register in the transfer state pulls one word
   assign acc  = hsel_i && hready_i && htrans_i[1];
   assign aoff = haddr_i[7:0];
   assign link.data_rd = acc && !hwrite_i && (aoff == `SMH_A_DATA) &&
                         (s_q.st == smh_pkg::SMH_H_XFER);
   assign go = s_q.wr_pend && (s_q.waddr == `SMH_A_CTRL) &&
               hwdata_i[`SMH_C_GO];

   // Bus decode, command sequencing and interrupt events
   always_comb begin
      s_d        = s_q;
      ev         = 3'h0;
      s_d.cmd_wr = 1'b0;
      s_d.wr_pend = acc && hwrite_i;
      s_d.waddr  = aoff;
      if (acc && !hwrite_i) begin
         case (aoff)
            `SMH_A_CTRL: s_d.rdata = {27'h0, s_q.dev, 1'b0, s_q.op, 1'b0};
            `SMH_A_STAT: s_d.rdata = {13'h0, link.dev_echo, s_q.en,
                                      (s_q.st != smh_pkg::SMH_H_IDLE),
                                      link.err_flags, link.st_flags};
            `SMH_A_DATA: s_d.rdata = {16'h0, link.rd_word};
            `SMH_A_IRQ:  s_d.rdata = {29'h0, s_q.irq};
            `SMH_A_MASK: s_d.rdata = {29'h0, s_q.mask};
            default:     s_d.rdata = 32'h0;
         endcase
      end
      if (s_q.wr_pend && s_q.waddr == `SMH_A_MASK) begin
         s_d.mask = hwdata_i[2:0];
      end
      case (s_q.st)
         smh_pkg::SMH_H_IDLE: begin
            if (go) begin
               s_d.op  = smh_pkg::smh_op_t'(hwdata_i[`SMH_C_OP_LSB +: 2]);
               s_d.dev = hwdata_i[`SMH_C_DEV];             // R11
               if (!link.st_flags[`SMH_ST_DRDY] ||
                   link.st_flags[`SMH_ST_BSY] ||
                   s_d.op == smh_pkg::SMH_OP_BAD ||
                   (s_d.op == smh_pkg::SMH_OP_READ && !s_q.en)) begin
                  ev[`SMH_I_ERR]  = 1'b1;                  // R09
                  ev[`SMH_I_DONE] = 1'b1;
               end else begin
                  case (s_d.op)
                     smh_pkg::SMH_OP_READ: s_d.feat = `SMH_FEAT_READ; // R12
                     smh_pkg::SMH_OP_EN:   s_d.feat = `SMH_FEAT_EN;   // R06
                     default:              s_d.feat = `SMH_FEAT_DIS;  // R08
                  endcase
                  s_d.cmd_wr = 1'b1;
                  s_d.st     = smh_pkg::SMH_H_CMD;
               end
            end
         end
         smh_pkg::SMH_H_CMD:  s_d.st = smh_pkg::SMH_H_WAIT;
         smh_pkg::SMH_H_WAIT: begin
            if (!link.st_flags[`SMH_ST_BSY]) begin
               if (link.st_flags[`SMH_ST_DRQ]) begin
                  ev[`SMH_I_DRQ] = 1'b1;
                  s_d.st = smh_pkg::SMH_H_XFER;
               end else begin
                  ev[`SMH_I_DONE] = 1'b1;
                  s_d.st = smh_pkg::SMH_H_IDLE;
                  if (link.st_flags[`SMH_ST_ERR]) begin
                     ev[`SMH_I_ERR] = 1'b1;
                  end else if (s_q.op == smh_pkg::SMH_OP_EN) begin
                     s_d.en = 1'b1;
                  end else if (s_q.op == smh_pkg::SMH_OP_DIS) begin
                     s_d.en = 1'b0;
                  end
               end
            end
         end
         smh_pkg::SMH_H_XFER: begin
            if (!link.st_flags[`SMH_ST_DRQ]) begin
               ev[`SMH_I_DONE] = 1'b1;
               s_d.st = smh_pkg::SMH_H_IDLE;
            end
         end
         default: s_d.st = smh_pkg::SMH_H_IDLE;
      endcase
      // Write one to clear; a new event in the same cycle wins
      if (s_q.wr_pend && s_q.waddr == `SMH_A_IRQ) begin
         s_d.irq = s_q.irq & ~hwdata_i[2:0];
      end
      s_d.irq = s_d.irq | ev;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Taskfile drive; signature bytes on every health command
   assign link.tf_feat     = s_q.feat;
   assign link.tf_lba_mid  = `SMH_SIG_MID;                 // R14
   assign link.tf_lba_high = `SMH_SIG_HIGH;                // R14
   assign link.tf_dev      = s_q.dev;                      // R11
   assign link.tf_cmd      = `SMH_CMD_HEALTH;
   assign link.cmd_wr      = s_q.cmd_wr;
   assign hrdata_o         = s_q.rdata;
   assign hreadyout_o      = 1'b1;
   assign hresp_o          = 1'b0;
   assign irq_o            = |(s_q.irq & s_q.mask);

endmodule : smh_host
`default_nettype wire

// File: testbench/smh_link_checker.sv
// Checker of the taskfile link between the host and device ends.
`timescale 1ns/100ps
`default_nettype none
module smh_link_checker (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [7:0]  tf_feat,
   input  wire logic [7:0]  tf_lba_mid,
   input  wire logic [7:0]  tf_lba_high,
   input  wire logic        tf_dev,
   input  wire logic [7:0]  tf_cmd,
   input  wire logic        cmd_wr,
   input  wire logic        data_rd,
   input  wire logic [7:0]  st_flags,
   input  wire logic [7:0]  err_flags,
   input  wire logic        dev_echo,
   input  wire logic [15:0] rd_word
);
   logic       idle;
   logic       good;
   logic       pop;
   logic       en_q;
   logic [8:0] cnt_q;
   logic [7:0] sum_q;
   // Device idle, a well-formed command strobe and a word pop
   assign idle = !st_flags[7] && !st_flags[3];
   assign good = cmd_wr && idle && tf_cmd == 8'hb0
                 && tf_lba_mid == 8'h4f && tf_lba_high == 8'hc2;
   assign pop  = data_rd && st_flags[3];
   // Shadow of the enabled state
   always_ff @(posedge clk_i) begin
      if (!reset_n_i)
         en_q <= 1'b0;
      else if (good && tf_feat == 8'hd8)
         en_q <= 1'b1;
      else if (good && tf_feat == 8'hd9)
         en_q <= 1'b0;
   end
   // Word count and byte sum of the block
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || cmd_wr) begin
         cnt_q <= 9'h000;
         sum_q <= 8'h00;
      end else if (pop) begin
         cnt_q <= cnt_q + 9'h001;
         sum_q <= sum_q + rd_word[7:0] + rd_word[15:8];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // One busy cycle, then clean or aborted completion
   sequence s_ok;
      st_flags[7] ##1 (st_flags == 8'h40 && err_flags == 8'h00);
   endsequence
   sequence s_abort;
      st_flags[7] ##1 (st_flags == 8'h41 && err_flags == 8'h04);
   endsequence
   a_enable_ok: assert property (good && tf_feat == 8'hd8 |=> s_ok)
      else $error("enable did not complete cleanly");
   a_disable_ok: assert property (
      good && tf_feat == 8'hd9 && en_q |=> s_ok)
      else $error("disable did not complete cleanly");
   a_disable_off: assert property (
      good && tf_feat == 8'hd9 && !en_q |=> s_abort)
      else $error("disable while off was not aborted");
   a_read_start: assert property (
      good && tf_feat == 8'hd0 && en_q |=> st_flags[7] ##1 st_flags == 8'h48)
      else $error("read did not enter data-in");
   a_echo_dev: assert property (
      cmd_wr && idle |=> ##1 dev_echo == $past(tf_dev, 2))
      else $error("device select not echoed");
   a_word_hold: assert property (
      st_flags[3] && !data_rd |=> $stable(rd_word))
      else $error("word moved without a pop");
   a_block_len: assert property (pop && cnt_q < 9'd255 |=> st_flags == 8'h48)
      else $error("block ended early");
   a_block_end: assert property (
      pop && cnt_q == 9'd255 |=> st_flags == 8'h40 && err_flags == 8'h00)
      else $error("block did not end after 256 words");
   a_checksum_ok: assert property (
      pop && cnt_q == 9'd255 |-> 8'(sum_q + rd_word[7:0] + rd_word[15:8]) == 8'h00)
      else $error("block sum is not zero");
   a_cmd_pulse: assert property (cmd_wr |=> !cmd_wr)
      else $error("command strobe longer than one cycle");
endmodule : smh_link_checker
`default_nettype wire

// File: testbench/test_smart_command_handler.sv
// Self-checking bench for the health command host and device ends.
`timescale 1ns/100ps
`default_nettype none
`include "smh_regs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module test_smart_command_handler;
   logic        clk_i     = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        hsel      = 1'b0;
   logic [31:0] haddr     = 32'h0;
   logic [1:0]  htrans    = 2'b00;
   logic        hwrite    = 1'b0;
   logic [31:0] hwdata    = 32'h0;
   logic [15:0] cnt16     = 16'hab01;
   logic [15:0] rtb       = 16'h0203;
   logic [7:0]  spr       = 8'h44;
   logic [15:0] ers       = 16'h0506;
   logic [2:0]  hsize     = 3'b010;
   logic [31:0] hrdata;
   wire logic   hready;
   wire logic   hresp;
   wire logic   irq;
   wire logic   en1;
   wire logic   busy1;
   wire logic   en2;
   int          fails     = 0;
   int          checks    = 0;
   int          ncmd      = 0;
   logic [7:0]  b [512];
   smh_if smh_if_i ();
   smh_if smh_if_x ();
   smh_dev #(.REV_CODE(16'h1234), .OFFLINE_ST(8'h5a), .SELFTEST(16'h0102),
      .CAPABILITY(16'h0003), .POLL_SHORT(8'h11), .POLL_EXT(8'h22),
      .POLL_CONV(8'h33)) smh_dev_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .link(smh_if_i.dev), .init_bad_i(cnt16), .rt_bad_i(rtb),
      .spare_i(spr), .erase_i(ers), .enabled_o(en1), .busy_o(busy1));
   smh_host smh_host_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .link(smh_if_i.host), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .irq_o(irq));
   // Second device, driven by the bench to break the link rules
   smh_dev smh_dev_x_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .link(smh_if_x.dev), .init_bad_i(cnt16), .rt_bad_i(rtb),
      .spare_i(spr), .erase_i(ers), .enabled_o(en2), .busy_o());
   smh_link_checker smh_link_checker_i (.clk_i(clk_i),
      .reset_n_i(reset_n_i), .tf_feat(smh_if_i.tf_feat),
      .tf_lba_mid(smh_if_i.tf_lba_mid), .tf_lba_high(smh_if_i.tf_lba_high),
      .tf_dev(smh_if_i.tf_dev), .tf_cmd(smh_if_i.tf_cmd),
      .cmd_wr(smh_if_i.cmd_wr), .data_rd(smh_if_i.data_rd),
      .st_flags(smh_if_i.st_flags), .err_flags(smh_if_i.err_flags),
      .dev_echo(smh_if_i.dev_echo), .rd_word(smh_if_i.rd_word));
   // Clock and command strobe count
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (smh_if_i.cmd_wr === 1'b1)
         ncmd++;
   end
   // One single AHB-Lite transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk_i); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   // Issue an order, poll for data ready or end of busy; no end is a fail
   task automatic go(input logic [1:0] op, input logic dev);
      logic [31:0] r;
      logic        ok;
      ok = 1'b0;
      bus(1'b1, `SMH_A_CTRL, {27'h0, dev, 1'b0, op, 1'b1}, r);
      for (int i = 0; i < 40 && !ok; i++) begin
         bus(1'b0, `SMH_A_STAT, 32'h0, r);
         ok = (r[16] === 1'b0) || (op == 2'd0 && r[3] === 1'b1);
      end
      `CHK("go ends", 1'b1, ok)
   endtask : go
   // Strobe a raw command into the second device, return its status
   task automatic raw(input logic [7:0] c, f, m, h,
                      output logic [15:0] s);
      smh_if_x.tf_cmd      <= c;
      smh_if_x.tf_feat     <= f;
      smh_if_x.tf_lba_mid  <= m;
      smh_if_x.tf_lba_high <= h;
      smh_if_x.cmd_wr     <= 1'b1;
      @(posedge clk_i);
      smh_if_x.cmd_wr <= 1'b0;
      repeat (2) @(posedge clk_i);
      s = {smh_if_x.err_flags, smh_if_x.st_flags};
   endtask : raw
   task automatic t_refuse;
      logic [31:0] r;
      bus(1'b0, `SMH_A_STAT, 32'h0, r);
      `CHK("stat reset", 32'h00000040, r)
      `CHK("okay", 1'b0, hresp)
      bus(1'b1, 8'h14, 32'hffffffff, r);
      bus(1'b0, 8'h14, 32'h0, r);
      `CHK("unmapped", 32'h0, r)
      go(2'd0, 1'b0);
      go(2'd3, 1'b0);
      `CHK("no strobe", 0, ncmd)
      bus(1'b0, `SMH_A_IRQ, 32'h0, r);
      `CHK("irq refuse", 32'h3, r)
      `CHK("irq masked", 1'b0, irq)
      bus(1'b1, `SMH_A_MASK, 32'h3, r);
      bus(1'b1, `SMH_A_IRQ, 32'h3, r);
      bus(1'b0, `SMH_A_IRQ, 32'h0, r);
      `CHK("irq clear", 32'h0, r)
      `CHK("irq low", 1'b0, irq)
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_modes;
      logic [31:0] r;
      go(2'd2, 1'b1);
      bus(1'b0, `SMH_A_STAT, 32'h0, r);
      `CHK("dis off", 32'h00040441, r)
      `CHK("irq set", 1'b1, irq)
      go(2'd1, 1'b0);
      bus(1'b0, `SMH_A_STAT, 32'h0, r);
      `CHK("enable", 32'h00020040, r)
      `CHK("enabled", 1'b1, en1)
      $display("test modes done");
   endtask : t_modes
   task automatic t_read;
      int unsigned p [16] = '{0, 1, 362, 364, 365, 368, 372, 373, 374,
                              396, 397, 398, 399, 400, 401, 402};
      logic [7:0]  v [16] = '{8'h34, 8'h12, 8'h5a, 8'h02, 8'h01, 8'h03,
                              8'h11, 8'h22, 8'h33, 8'hab, 8'h01, 8'h02,
                              8'h03, 8'h44, 8'h05, 8'h06};
      logic [7:0]  sum;
      logic [31:0] r;
      sum = 8'h00;
      foreach (b[i])
         b[i] = 8'h00;
      foreach (p[i])
         b[p[i]] = v[i];
      for (int i = 0; i < 511; i++)
         sum = sum + b[i];
      b[511] = 8'h00 - sum;
      go(2'd0, 1'b1);
      cnt16 <= 16'hffff; // Counters move after the snapshot
      `CHK("busy", 1'b1, busy1)
      for (int k = 0; k < 256; k++) begin
         bus(1'b0, `SMH_A_DATA, 32'h0, r);
         `CHK("word", {16'h0, b[2*k+1], b[2*k]}, r)
      end
      go(2'd1, 1'b1);
      bus(1'b0, `SMH_A_STAT, 32'h0, r);
      `CHK("read end", 32'h00060040, r)
      bus(1'b0, `SMH_A_IRQ, 32'h0, r);
      `CHK("data irq", 1'b1, r[2])
      go(2'd2, 1'b0);
      bus(1'b0, `SMH_A_STAT, 32'h0, r);
      `CHK("disable", 32'h00000040, r)
      `CHK("disabled", 1'b0, en1)
      $display("test read done");
   endtask : t_read
   task automatic t_link;
      logic [15:0] s;
      raw(8'hb0, 8'hd8, 8'h00, 8'hc2, s);
      `CHK("bad sig", 16'h0441, s)
      raw(8'hb0, 8'hd8, 8'h4f, 8'h00, s);
      `CHK("bad high", 16'h0441, s)
      raw(8'ha0, 8'hd8, 8'h4f, 8'hc2, s);
      `CHK("bad cmd", 16'h0441, s)
      raw(8'hb0, 8'h12, 8'h4f, 8'hc2, s);
      `CHK("bad feat", 16'h0441, s)
      raw(8'hb0, 8'hd0, 8'h4f, 8'hc2, s);
      `CHK("read off", 16'h0441, s)
      `CHK("still off", 1'b0, en2)
      raw(8'hb0, 8'hd8, 8'h4f, 8'hc2, s);
      `CHK("enable x", 16'h0040, s)
      `CHK("x on", 1'b1, en2)
      $display("test link done");
   endtask : t_link
   task automatic conclude;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      smh_if_x.tf_feat     = 8'h00;
      smh_if_x.tf_lba_mid  = 8'h00;
      smh_if_x.tf_lba_high = 8'hc2;
      smh_if_x.tf_dev      = 1'b0;
      smh_if_x.tf_cmd      = 8'h00;
      smh_if_x.cmd_wr      = 1'b0;
      smh_if_x.data_rd     = 1'b0;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      t_refuse();
      t_modes();
      t_read();
      t_link();
      conclude();
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (8000) @(posedge clk_i);
      fails++;
      conclude();
   end
endmodule : test_smart_command_handler
`default_nettype wire
